// ===== settings_ones_count_pkg.sv
// package with command codes, field positions, reset values and timing for the settings checksum block
package settings_ones_count_pkg;
  // -----------------------------------------------------------------
  // command codes, equal to register addresses
  // -----------------------------------------------------------------
  localparam logic [15:0] FAULT_CLEAR_CMD       = 16'h0003;
  localparam logic [15:0] SAVE_USER_CMD         = 16'h0015;
  localparam logic [15:0] LOAD_USER_CMD         = 16'h0016;
  localparam logic [15:0] CHECKSUM_READBACK_CMD = 16'h00D1;
  localparam logic [15:0] LATCHED_FAULT_ONE_CMD = 16'hFE81;
  // -----------------------------------------------------------------
  // fields and reset values
  // -----------------------------------------------------------------
  localparam int          CSUM_FAULT_BIT  = 5;
  localparam logic [7:0]  READBACK_RST    = 8'h00;
  localparam logic [7:0]  ACC_RST         = 8'h00;
  localparam logic [7:0]  UNMAPPED_RDATA  = 8'h00;
  // -----------------------------------------------------------------
  // timing: least wait after a save before the next command
  // -----------------------------------------------------------------
  localparam int          CLK_HZ          = 20000000;
  localparam int          SAVE_WAIT_MS    = 35;
  localparam int          SAVE_WAIT_CYC   = (SAVE_WAIT_MS * (CLK_HZ / 1000));
  localparam int          WAIT_CNT_W      = 20;
  localparam logic [WAIT_CNT_W-1:0] WAIT_CNT_RST = 20'h00000;
  // -----------------------------------------------------------------
  // sequencer states
  // -----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_ERASE = 3'b001,
    ST_SAVE  = 3'b010,
    ST_CSUM  = 3'b011,
    ST_LOAD  = 3'b100
  } xfer_state_t;
endpackage

// ===== ones_count.sv
// combinational count of one bits in one data byte
`timescale 1ns/1ns
module ones_count
#(
  parameter int DATA_W = 8
)
(
  input  wire logic [DATA_W-1:0] data_i,
  output logic      [3:0]        ones_o
);
  // -----------------------------------------------------------------
  // bit sum
  // -----------------------------------------------------------------
  // a plain loop is enough here; the byte is narrow so no adder tree
  always_comb
  begin
    ones_o = 4'h0;
    for (int i = 0; i < DATA_W; i++)
    begin
      ones_o = ones_o + {3'h0, data_i[i]};
    end
  end
endmodule

// ===== settings_ones_count_checksum.sv
// settings save/load sequencer with ones-count checksum and latched fault flag
//
// Overview of operation
// - save counts ones, writes count last byte
// - load counts ones of bytes given registers
// - mismatch on load sets fault bit five
// - match on load leaves fault flag clear
// - readback command returns last load count
// - accumulator eight bits, wraps past 255
// - register address equals its command code
// - load at power-up and on command
// - save erases page first; host waits 35ms
// - fault clear command clears checksum fault
`timescale 1ns/1ns
module settings_ones_count_checksum
#(
  parameter int SAVE_WAIT = settings_ones_count_pkg::SAVE_WAIT_CYC
)
(
  input  wire logic                           core_clk_i,
  input  wire logic                           sys_rst_i,
  // command / register port
  input  wire logic [15:0]                    reg_addr_i,
  input  wire logic                           reg_wr_i,
  input  wire logic                           reg_rd_i,
  output logic      [7:0]                     reg_rdata_o,
  output logic                                reg_ack_o,
  output logic                                busy_o,
  // settings source for a save
  input  wire logic [7:0]                     set_byte_i,
  input  wire logic                           set_valid_i,
  input  wire logic                           set_last_i,
  output logic                                set_ready_o,
  // nonvolatile user page
  output logic                                nvm_erase_o,
  input  wire logic                           nvm_erase_done_i,
  output logic                                nvm_wr_o,
  output logic      [7:0]                     nvm_wdata_o,
  output logic                                nvm_rd_start_o,
  input  wire logic [7:0]                     nvm_rdata_i,
  input  wire logic                           nvm_rvalid_i,
  input  wire logic                           nvm_rlast_i,
  // settings sink for a load
  output logic                                regs_we_o,
  output logic      [7:0]                     regs_wdata_o,
  output logic                                csum_fault_o
);
  import settings_ones_count_pkg::*;

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  xfer_state_t             state_ff;
  logic [7:0]              acc_ff;
  logic [7:0]              readback_ff;
  logic                    fault_ff;
  logic                    por_pend_ff;
  logic [WAIT_CNT_W-1:0]   wait_ff;
  logic [3:0]              ones_in;
  logic [7:0]              ones_src;
  logic                    start_save;
  logic                    start_load;
  logic                    save_beat;
  logic                    load_beat;
  logic                    load_end;
  logic                    csum_bad;
  logic                    clear_cmd;
  logic [7:0]              flag_word;

  localparam logic [WAIT_CNT_W-1:0] WAIT_LOAD = WAIT_CNT_W'(SAVE_WAIT);

  // decode of one command code from the register address, for reads and writes
  function automatic logic cmd_hit(input logic [15:0] addr, input logic [15:0] code);
    cmd_hit = (addr == code);
  endfunction

  // -----------------------------------------------------------------
  // command decode and beats
  // -----------------------------------------------------------------
  // save/load only start when idle and the save wait has run out; a
  // command in that time is dropped, the host is asked to wait anyway
  assign busy_o      = (state_ff != ST_IDLE) || (wait_ff != WAIT_CNT_RST);
  assign clear_cmd   = reg_wr_i && cmd_hit(reg_addr_i, FAULT_CLEAR_CMD);
  assign start_save  = !busy_o && reg_wr_i && cmd_hit(reg_addr_i, SAVE_USER_CMD);
  assign start_load  = !busy_o && !start_save
                       && (por_pend_ff || (reg_wr_i && cmd_hit(reg_addr_i, LOAD_USER_CMD)));
  assign set_ready_o = (state_ff == ST_SAVE);
  assign save_beat   = set_ready_o && set_valid_i;
  assign load_beat   = (state_ff == ST_LOAD) && nvm_rvalid_i && !nvm_rlast_i;
  assign load_end    = (state_ff == ST_LOAD) && nvm_rvalid_i && nvm_rlast_i;
  assign csum_bad    = load_end && (nvm_rdata_i != acc_ff);
  assign ones_src    = (state_ff == ST_SAVE) ? set_byte_i : nvm_rdata_i;
  assign csum_fault_o = fault_ff;
  assign flag_word    = {7'h00, fault_ff} << CSUM_FAULT_BIT;

  ones_count
  #(
    .DATA_W (8)
  )
  u_ones
  (
    .data_i (ones_src),
    .ones_o (ones_in)
  );

  // -----------------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------------
  // save: erase, stream bytes, then checksum byte; load: stream until last
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      state_ff <= ST_IDLE;
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (start_save)
            state_ff <= ST_ERASE;
          else if (start_load)
            state_ff <= ST_LOAD;
        end
        ST_ERASE:
        begin
          if (nvm_erase_done_i)
            state_ff <= ST_SAVE;
        end
        ST_SAVE:
        begin
          if (save_beat && set_last_i)
            state_ff <= ST_CSUM;
        end
        ST_CSUM:
          state_ff <= ST_IDLE;
        ST_LOAD:
        begin
          if (load_end)
            state_ff <= ST_IDLE;
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // power-up load request, dropped once the load has begun
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      por_pend_ff <= 1'b1;
    else if (start_load)
      por_pend_ff <= 1'b0;
  end

  // save wait counter; a host ignoring the wait is simply not served
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      wait_ff <= WAIT_CNT_RST;
    else if (start_save)
      wait_ff <= WAIT_LOAD;
    else if (wait_ff != WAIT_CNT_RST)
      wait_ff <= wait_ff - 1'b1;
  end

  // -----------------------------------------------------------------
  // ones accumulator
  // -----------------------------------------------------------------
  // eight bits on purpose: the carry out is dropped so the count wraps
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      acc_ff <= ACC_RST;
    else if (start_save || start_load)
      acc_ff <= ACC_RST;
    else if (save_beat || load_beat)
      acc_ff <= acc_ff + {4'h0, ones_in};
  end

  // -----------------------------------------------------------------
  // data paths to the page and the registers
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      nvm_erase_o    <= 1'b0;
      nvm_rd_start_o <= 1'b0;
      nvm_wr_o       <= 1'b0;
      nvm_wdata_o    <= 8'h00;
      regs_we_o      <= 1'b0;
      regs_wdata_o   <= 8'h00;
    end
    else
    begin
      nvm_erase_o    <= start_save;
      nvm_rd_start_o <= start_load;
      nvm_wr_o       <= save_beat || (state_ff == ST_CSUM);
      regs_we_o      <= load_beat;
      if (save_beat)
        nvm_wdata_o <= set_byte_i;
      else if (state_ff == ST_CSUM)
        nvm_wdata_o <= acc_ff;
      if (load_beat)
        regs_wdata_o <= nvm_rdata_i;
    end
  end

  // -----------------------------------------------------------------
  // readback and fault flag
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      readback_ff <= READBACK_RST;
    else if (load_end)
      readback_ff <= acc_ff;
  end

  // a mismatch in the cycle of a clear still sets the flag
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      fault_ff <= 1'b0;
    else if (csum_bad)
      fault_ff <= 1'b1;
    else if (clear_cmd)
      fault_ff <= 1'b0;
  end

  // -----------------------------------------------------------------
  // register reads
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      reg_rdata_o <= UNMAPPED_RDATA;
      reg_ack_o   <= 1'b0;
    end
    else
    begin
      reg_ack_o <= reg_rd_i || reg_wr_i;
      if (reg_rd_i)
      begin
        if (cmd_hit(reg_addr_i, CHECKSUM_READBACK_CMD))
          reg_rdata_o <= readback_ff;
        else if (cmd_hit(reg_addr_i, LATCHED_FAULT_ONE_CMD))
          reg_rdata_o <= flag_word;
        else
          reg_rdata_o <= UNMAPPED_RDATA;
      end
    end
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  csum_byte_write_a: assert property ((state_ff == ST_CSUM) |=> nvm_wr_o && (nvm_wdata_o == $past(acc_ff)))
    else $error("checksum byte not written after save");
  load_count_step_a: assert property (load_beat |=> (acc_ff == 8'($past(acc_ff) + {4'h0, $past(ones_in)})) && regs_we_o)
    else $error("load count did not advance by byte ones");
  mismatch_fault_a: assert property (csum_bad |=> fault_ff && csum_fault_o)
    else $error("mismatch did not set checksum fault");
  match_no_fault_a: assert property (load_end && !csum_bad && !fault_ff |=> !fault_ff)
    else $error("matching load set checksum fault");
  readback_latch_a: assert property (load_end |=> (readback_ff == $past(acc_ff)))
    else $error("readback not taken from load count");
  acc_wrap_a: assert property ((save_beat || load_beat) && (({1'b0, acc_ff} + {5'h00, ones_in}) > 9'h0FF)
                               |=> (acc_ff == 8'({1'b0, $past(acc_ff)} + {5'h00, $past(ones_in)} - 9'h100)))
    else $error("accumulator did not wrap");
  flag_addr_map_a: assert property (reg_rd_i && (reg_addr_i == LATCHED_FAULT_ONE_CMD)
                                    |=> reg_ack_o && (reg_rdata_o == {2'b00, $past(fault_ff), 5'b00000}))
    else $error("latched flag read wrong");
  por_load_a: assert property (por_pend_ff && (state_ff == ST_IDLE) && !busy_o |=> (state_ff == ST_LOAD) ##0 nvm_rd_start_o)
    else $error("power-up load not started");
  erase_first_a: assert property (start_save |=> nvm_erase_o && (state_ff == ST_ERASE) ##1 busy_o [*8])
    else $error("save did not erase first or hold busy");
  fault_clear_a: assert property (clear_cmd && !csum_bad |=> !fault_ff)
    else $error("fault clear ignored");
  acc_zero_start_a: assert property (start_save || start_load |=> (acc_ff == ACC_RST))
    else $error("accumulator not zeroed at start");

  save_done_c: cover property ((state_ff == ST_CSUM) ##1 (state_ff == ST_IDLE));
  load_good_c: cover property (load_end && !csum_bad);
  load_bad_c:  cover property (csum_bad);
  clear_set_c: cover property (clear_cmd && csum_bad);
endmodule

// ===== nvm_page_model.sv
// behavioural model of the nonvolatile user page behind the checksum block
`timescale 1ns/1ns
module nvm_page_model
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       erase_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       rd_start_i,
  input  wire logic       corrupt_i,
  output logic            erase_done_o,
  output logic      [7:0] rdata_o,
  output logic            rvalid_o,
  output logic            rlast_o
);
  logic [7:0] page [0:63];
  int         len;
  int         ecnt;
  int         rptr;
  logic       reading;
  // page holds one byte and its matching count before the first power-up
  initial
  begin
    page[0] = 8'h0F;
    page[1] = 8'h04;
    len     = 2;
  end
  // erase, append-only writes and streamed reads; idle read data toggles
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      erase_done_o <= 1'b0;
      rvalid_o     <= 1'b0;
      rlast_o      <= 1'b0;
      rdata_o      <= 8'hA5;
      ecnt         <= 0;
      reading      <= 1'b0;
    end
    else
    begin
      erase_done_o <= 1'b0;
      rvalid_o     <= 1'b0;
      rlast_o      <= 1'b0;
      rdata_o      <= ~rdata_o;
      if (erase_i)
        ecnt <= 6;
      else if (ecnt > 1)
        ecnt <= ecnt - 1;
      else if (ecnt == 1)
      begin
        ecnt         <= 0;
        erase_done_o <= 1'b1;
        len          <= 0;
      end
      if (wr_i)
      begin
        page[len] <= wdata_i;
        len       <= len + 1;
      end
      if (rd_start_i)
      begin
        reading <= 1'b1;
        rptr    <= 0;
      end
      else if (reading)
      begin
        rvalid_o <= 1'b1;
        rdata_o  <= (rptr == 0 && corrupt_i) ? page[0] ^ 8'h01 : page[rptr];
        rlast_o  <= (rptr == len - 1);
        reading  <= (rptr != len - 1);
        rptr     <= rptr + 1;
      end
    end
  end
endmodule

// ===== testbench.sv
// self-checking bench for the settings ones-count checksum block
`timescale 1ns/1ns
module testbench;
  import settings_ones_count_pkg::*;
  logic        clk, rst, wr, rd, sv, sl, corrupt, ack, busy, srdy;
  logic        ner, ndone, nwr, nst, nrv, nrl, rwe, fault;
  logic [15:0] addr;
  logic [7:0]  sb, rdata, nwd, nrd, rwd, got, last_rwd;
  int          n_fail, n_checks, n_we;
  // short save wait keeps the run brief
  settings_ones_count_checksum #(.SAVE_WAIT(20)) settings_ones_count_checksum_inst
  (
    .core_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .reg_ack_o(ack), .busy_o(busy), .set_byte_i(sb), .set_valid_i(sv),
    .set_last_i(sl), .set_ready_o(srdy), .nvm_erase_o(ner), .nvm_erase_done_i(ndone),
    .nvm_wr_o(nwr), .nvm_wdata_o(nwd), .nvm_rd_start_o(nst), .nvm_rdata_i(nrd),
    .nvm_rvalid_i(nrv), .nvm_rlast_i(nrl), .regs_we_o(rwe), .regs_wdata_o(rwd),
    .csum_fault_o(fault)
  );
  nvm_page_model nvm_page_model_inst
  (
    .clk_i(clk), .rst_i(rst), .erase_i(ner), .wr_i(nwr), .wdata_i(nwd), .rd_start_i(nst),
    .corrupt_i(corrupt), .erase_done_o(ndone), .rdata_o(nrd), .rvalid_o(nrv), .rlast_o(nrl)
  );
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // counts register loads forwarded by the block
  always @(posedge clk)
    if (rwe === 1'b1)
    begin
      n_we++;
      last_rwd = rwd;
    end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task final_report;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk8(input string name, input logic [7:0] exp, input logic [7:0] seen);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one-cycle strobe, then a bounded wait for the acknowledge
  task access(input logic [15:0] a, input logic w);
    int i;
    @(negedge clk);
    addr = a;
    wr   = w;
    rd   = !w;
    for (i = 0; i < 4; i++)
    begin
      @(negedge clk);
      wr = 1'b0;
      rd = 1'b0;
      if (ack === 1'b1)
        break;
    end
    if (i == 4)
    begin
      n_fail++;
      final_report();
    end
    got = rdata;
  endtask
  task wait_idle;
    int i;
    for (i = 0; i < 3000 && busy !== 1'b0; i++)
      @(negedge clk);
    if (i == 3000)
    begin
      n_fail++;
      final_report();
    end
  endtask
  // streams n all-ones bytes; ready seen at a falling edge means taken next edge
  task do_save(input int n);
    int   i, k;
    logic acc;
    k = 0;
    access(SAVE_USER_CMD, 1'b1);
    sv = 1'b1;
    sb = 8'hFF;
    sl = (n == 1);
    for (i = 0; i < 300 && k < n; i++)
    begin
      acc = (srdy === 1'b1);
      @(negedge clk);
      if (acc)
      begin
        k++;
        sl = (k == n - 1);
        sv = (k < n);
      end
    end
    if (k < n)
    begin
      n_fail++;
      final_report();
    end
  endtask
  task do_load;
    n_we = 0;
    access(LOAD_USER_CMD, 1'b1);
    wait_idle();
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {wr, rd, sv, sl, corrupt} = '0;
    addr  = 16'h0000;
    sb    = 8'h00;
    n_fail = 0;
    n_checks = 0;
    n_we  = 0;
    rst   = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    wait_idle();
    access(CHECKSUM_READBACK_CMD, 1'b0);
    chk8("readback after power-up", 8'h04, got);
    chk8("power-up data", 8'h0F, last_rwd);
    access(LATCHED_FAULT_ONE_CMD, 1'b0);
    chk8("flags after power-up", 8'h00, got);
    access(16'h0055, 1'b0);
    chk8("unmapped read", UNMAPPED_RDATA, got);
    $display("test power-up load done");
    // 33 full bytes give 264 ones, which wraps to 8
    do_save(33);
    wait_idle();
    // the checksum byte reaches the page one edge after the block goes idle
    repeat (2) @(negedge clk);
    chk8("page length", 8'(nvm_page_model_inst.len), 8'd34);
    chk8("stored count", 8'h08, nvm_page_model_inst.page[33]);
    chk8("first stored byte", 8'hFF, nvm_page_model_inst.page[0]);
    $display("test save done");
    do_load();
    chk8("loaded bytes", 8'd33, 8'(n_we));
    chk8("loaded data", 8'hFF, last_rwd);
    access(CHECKSUM_READBACK_CMD, 1'b0);
    chk8("readback after load", 8'h08, got);
    access(CHECKSUM_READBACK_CMD, 1'b1);
    access(CHECKSUM_READBACK_CMD, 1'b0);
    chk8("readback after write", 8'h08, got);
    access(LATCHED_FAULT_ONE_CMD, 1'b0);
    chk8("flags after good load", 8'h00, got);
    $display("test load done");
    corrupt = 1'b1;
    do_load();
    corrupt = 1'b0;
    access(CHECKSUM_READBACK_CMD, 1'b0);
    chk8("readback after bad load", 8'h07, got);
    access(LATCHED_FAULT_ONE_CMD, 1'b0);
    chk8("flags after bad load", 8'h20, got);
    chk8("fault pin set", 8'h01, {7'h00, fault});
    $display("test bad load done");
    access(FAULT_CLEAR_CMD, 1'b1);
    access(LATCHED_FAULT_ONE_CMD, 1'b0);
    chk8("flags after clear", 8'h00, got);
    chk8("fault pin clear", 8'h00, {7'h00, fault});
    do_load();
    access(CHECKSUM_READBACK_CMD, 1'b0);
    chk8("readback after reload", 8'h08, got);
    $display("test clear and reload done");
    final_report();
  end
endmodule
